// ===== inc/ucb_pkg.sv
package ucb_pkg;
  // APB register byte offsets
  localparam logic [7:0] UCB_OFF_CTRL = 8'h00;
  localparam logic [7:0] UCB_OFF_TX_ID = 8'h04;
  localparam logic [7:0] UCB_OFF_ACC_CODE = 8'h08;
  localparam logic [7:0] UCB_OFF_ACC_MASK = 8'h0C;
  localparam logic [7:0] UCB_OFF_STATUS = 8'h10;
  localparam logic [7:0] UCB_OFF_IRQ_MASK = 8'h14;
  // Control field positions (bits 3..0 of CTRL)
  localparam int UCB_CTRL_FIXED_ID = 0;
  localparam int UCB_CTRL_EXT = 1;
  localparam int UCB_CTRL_RESP_ID = 2;
  localparam int UCB_CTRL_END_CHAR = 3;
  localparam int UCB_CTRL_W = 4;
  // Status / interrupt bit positions
  localparam int UCB_ST_TX_SENT = 0;
  localparam int UCB_ST_RX_ACC = 1;
  localparam int UCB_ST_RX_REJ = 2;
  localparam int UCB_ST_OVF = 3;
  localparam int UCB_ST_W = 4;
  // Reset values
  localparam logic [3:0] UCB_CTRL_RST = 4'h1;
  localparam logic [28:0] UCB_TX_ID_RST = 29'h0000001;
  localparam logic [28:0] UCB_CODE_RST = 29'h0000000;
  localparam logic [28:0] UCB_MASK_RST = 29'h0000000;
  localparam logic [3:0] UCB_IRQM_RST = 4'h0;
  // Identifier widths and frame layout
  localparam int UCB_STD_ID_W = 11;
  localparam int UCB_EXT_ID_W = 29;
  localparam int UCB_MAX_DLC = 8;
  localparam int UCB_HDR_LEN = 3;
  localparam logic [7:0] UCB_CR = 8'h0D;
  // Timing: error light time, clock rate, idle gap that closes a message
  localparam int UCB_ERR_MS = 300;
  localparam int UCB_CLK_KHZ = 200000;
  localparam int UCB_ERR_CYC = UCB_ERR_MS * UCB_CLK_KHZ;
  localparam int UCB_IDLE_NS = 1000;
  localparam int UCB_CLK_PER_NS = 5;
  localparam int UCB_IDLE_CYC = UCB_IDLE_NS / UCB_CLK_PER_NS;

  // One CAN frame; data byte k sits at data[8*k +: 8]
  typedef struct packed {
    logic ext;
    logic [28:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } ucb_frame_t;

  // Control register layout, MSB first
  typedef struct packed {
    logic end_char;
    logic resp_id;
    logic ext;
    logic fixed_id;
  } ucb_ctrl_t;
endpackage

// ===== verilog/ucb_hex.sv
`timescale 1ns/1ps
module ucb_hex
  import ucb_pkg::*;
(
  // Nibble to ASCII
  input wire logic [3:0] i_nib,
  output logic [7:0] o_char,
  // ASCII to nibble
  input wire logic [7:0] i_char,
  output logic [3:0] o_nib,
  output logic o_is_hex
);
  wire is_dig = (i_char >= 8'h30) && (i_char <= 8'h39);
  wire is_up = (i_char >= 8'h41) && (i_char <= 8'h46);
  wire is_lo = (i_char >= 8'h61) && (i_char <= 8'h66);
  wire [7:0] dig_v = i_char - 8'h30;
  wire [7:0] up_v = i_char - 8'h37;
  wire [7:0] lo_v = i_char - 8'h57;

  // Upper-case digits on output; either case accepted on input
  assign o_char = (i_nib < 4'hA) ? (8'h30 + {4'h0, i_nib}) : (8'h37 + {4'h0, i_nib});
  assign o_is_hex = is_dig | is_up | is_lo;
  // Non-hex characters decode as zero
  assign o_nib = is_dig ? dig_v[3:0] : (is_up ? up_v[3:0] : (is_lo ? lo_v[3:0] : 4'h0));
endmodule // ucb_hex

// ===== verilog/ucb_filter.sv
`timescale 1ns/1ps
module ucb_filter
  import ucb_pkg::*;
(
  // Frame identifier
  input wire logic [28:0] i_id,
  input wire logic i_ext,
  // Acceptance code and mask
  input wire logic [28:0] i_code,
  input wire logic [28:0] i_mask,
  // Result
  output logic o_pass
);
  // Standard frames only look at the low 11 identifier bits
  wire [28:0] mask_eff = i_ext ? i_mask : {18'h00000, i_mask[UCB_STD_ID_W-1:0]};
  wire [28:0] diff = (i_id ^ i_code) & mask_eff;

  assign o_pass = (diff == 29'h0000000);
endmodule // ucb_filter

// ===== verilog/ucb_bridge.sv
`timescale 1ns/1ps
module ucb_bridge
  import ucb_pkg::*;
#(
  parameter int BUF_DEPTH = 72,
  parameter int ERR_CYCLES = UCB_ERR_CYC,
  parameter int IDLE_CYCLES = UCB_IDLE_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Serial bytes in
  input wire logic i_ser_in_valid,
  input wire logic [7:0] i_ser_in_data,
  output logic o_ser_in_ready,
  // Serial bytes out
  output logic o_ser_out_valid,
  output logic [7:0] o_ser_out_data,
  input wire logic i_ser_out_ready,
  // CAN frames out
  output logic o_can_tx_valid,
  output ucb_frame_t o_can_tx_frame,
  input wire logic i_can_tx_ready,
  // CAN frames in
  input wire logic i_can_rx_valid,
  input wire ucb_frame_t i_can_rx_frame,
  // Error light, watchdog, interrupt
  output logic o_err_led,
  output logic o_wdt_rst,
  output logic o_irq
);
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(BUF_DEPTH);

  // Refuse sizes that the buffer and the counters cannot serve
  if (BUF_DEPTH < UCB_HDR_LEN + UCB_MAX_DLC || ERR_CYCLES < 2 || IDLE_CYCLES < 2 ||
      IDLE_CYCLES > 65535) begin : g_bad_param
    $error("ucb_bridge: parameter out of range");
  end

  // Registers
  ucb_ctrl_t ctrl_reg;
  logic [28:0] tx_id_reg, code_reg, mask_reg;
  logic [3:0] stat_reg, irqm_reg;
  // Transmit assembly
  logic [63:0] acc_reg;
  logic [3:0] tx_cnt_reg;
  logic [1:0] hdr_cnt_reg;
  logic [11:0] dyn_id_reg;
  logic [15:0] idle_reg;
  logic tx_pend_reg;
  ucb_frame_t tx_out_reg;
  // Receive path
  ucb_frame_t hold_reg;
  logic hold_vld_reg;
  logic [3:0] idx_reg;
  logic [7:0] buf_reg [BUF_DEPTH];
  logic [CW-1:0] cnt_reg, rd_reg;
  logic drain_reg;
  // Error and watchdog
  logic err_act_reg, wdt_reg;
  logic [31:0] err_cnt_reg;

  // APB decode; zero wait states
  wire apb_acc = i_psel & i_penable;
  wire apb_wr = apb_acc & i_pwrite;
  wire apb_rd = apb_acc & ~i_pwrite;
  wire sel_ctrl = i_paddr == UCB_OFF_CTRL;
  wire sel_txid = i_paddr == UCB_OFF_TX_ID;
  wire sel_code = i_paddr == UCB_OFF_ACC_CODE;
  wire sel_mask = i_paddr == UCB_OFF_ACC_MASK;
  wire sel_stat = i_paddr == UCB_OFF_STATUS;
  wire sel_irqm = i_paddr == UCB_OFF_IRQ_MASK;
  wire mapped = sel_ctrl | sel_txid | sel_code | sel_mask | sel_stat | sel_irqm;
  assign o_pready = 1'b1;
  assign o_pslverr = apb_acc & ~mapped;
  assign o_prdata = sel_ctrl ? {28'h0000000, ctrl_reg} :
                    sel_txid ? {3'h0, tx_id_reg} :
                    sel_code ? {3'h0, code_reg} :
                    sel_mask ? {3'h0, mask_reg} :
                    sel_stat ? {28'h0000000, stat_reg} :
                    sel_irqm ? {28'h0000000, irqm_reg} : 32'h00000000;

  // Serial input: everything is data, header chars only in dynamic mode
  wire byte_in = i_ser_in_valid & o_ser_in_ready;
  wire hdr_phase = ~ctrl_reg.fixed_id & (hdr_cnt_reg < 2'(UCB_HDR_LEN));
  // A byte may land in the cycle the pending frame leaves, so streams run on
  wire store = byte_in & ~hdr_phase & (~tx_pend_reg | i_can_tx_ready);
  wire ser_ovf = byte_in & ~hdr_phase & tx_pend_reg & ~i_can_tx_ready;
  wire msg_open = (tx_cnt_reg != 4'h0) | (hdr_cnt_reg != 2'h0);
  wire gap_hit = msg_open & ~byte_in & (idle_reg == 16'(IDLE_CYCLES - 1));
  wire go_pend = (store & (tx_cnt_reg == 4'(UCB_MAX_DLC - 1))) |
                 (gap_hit & (tx_cnt_reg != 4'h0));
  wire tx_sent = tx_pend_reg & i_can_tx_ready;
  wire [3:0] hex_nib;
  wire [63:0] acc_next;
  wire [3:0] dlc_next = store ? tx_cnt_reg + 4'h1 : tx_cnt_reg;
  wire [28:0] id_next = ctrl_reg.fixed_id ? tx_id_reg : {17'h00000, dyn_id_reg};
  wire [28:0] id_fmt = ctrl_reg.ext ? id_next : {18'h00000, id_next[UCB_STD_ID_W-1:0]};

  // Byte lane write into the frame assembly word
  genvar g;
  generate
    for (g = 0; g < UCB_MAX_DLC; g++) begin : g_lane
      assign acc_next[8*g +: 8] = (store && tx_cnt_reg == 4'(g)) ? i_ser_in_data :
                                  acc_reg[8*g +: 8];
    end
  endgenerate

  assign o_can_tx_valid = tx_pend_reg;
  assign o_can_tx_frame = tx_out_reg;

  // Receive filter and serialiser
  wire rx_pass;
  // Frames are refused during the error time and the clearing cycle
  wire rx_in = i_can_rx_valid & ~err_act_reg & ~wdt_reg;
  wire rx_acc = rx_in & rx_pass;
  wire rx_rej = rx_in & ~rx_pass;
  wire can_ovf = rx_acc & hold_vld_reg;
  wire [3:0] dlc_cap = (hold_reg.dlc > 4'(UCB_MAX_DLC)) ? 4'(UCB_MAX_DLC) : hold_reg.dlc;
  wire [3:0] end_idx = 4'(UCB_HDR_LEN) + dlc_cap;
  wire [3:0] data_idx = idx_reg - 4'(UCB_HDR_LEN);
  wire [3:0] pfx_nib = (idx_reg == 4'h0) ? hold_reg.id[11:8] :
                       (idx_reg == 4'h1) ? hold_reg.id[7:4] : hold_reg.id[3:0];
  wire [7:0] pfx_char;
  wire [7:0] data_byte = hold_reg.data[8*data_idx[2:0] +: 8];
  wire in_pfx = idx_reg < 4'(UCB_HDR_LEN);
  wire [7:0] app_byte = in_pfx ? pfx_char : data_byte;
  wire buf_full = cnt_reg == DEPTH_C;
  wire app_want = hold_vld_reg & ~drain_reg & (idx_reg < end_idx);
  wire app_en = app_want & ~buf_full;
  wire buf_ovf = app_want & buf_full;
  wire app_cr = app_en & ~in_pfx & (data_byte == UCB_CR);
  wire hold_fin = hold_vld_reg & ~drain_reg & (idx_reg == end_idx);
  wire pop = drain_reg & i_ser_out_ready;
  wire pop_last = pop & (rd_reg == cnt_reg - CW'(1));
  // Immediate mode drains each frame; end-char mode only on CR
  wire start_drain = ctrl_reg.end_char ? app_cr : (hold_fin & (cnt_reg != '0));
  assign o_ser_out_valid = drain_reg;
  assign o_ser_out_data = buf_reg[rd_reg];

  // Error handling: overflow of any buffer ends in a watchdog reset
  wire ovf_ev = ser_ovf | can_ovf | buf_ovf;
  wire err_done = err_act_reg & (err_cnt_reg == 32'(ERR_CYCLES - 1));
  wire soft_rst = wdt_reg;
  assign o_err_led = err_act_reg;
  assign o_wdt_rst = wdt_reg;
  assign o_ser_in_ready = ~err_act_reg & ~wdt_reg;
  assign o_irq = |(stat_reg & irqm_reg);

  wire [3:0] ev = {ovf_ev, rx_rej, rx_acc, tx_sent};
  wire [3:0] stat_next = (stat_reg & ~((apb_rd & sel_stat) ? 4'hF : 4'h0)) | ev;

  ucb_filter u_filter (
    .i_id(i_can_rx_frame.id),
    .i_ext(i_can_rx_frame.ext),
    .i_code(code_reg),
    .i_mask(mask_reg),
    .o_pass(rx_pass)
  );

  ucb_hex u_hex (
    .i_nib(pfx_nib),
    .o_char(pfx_char),
    .i_char(i_ser_in_data),
    .o_nib(hex_nib),
    .o_is_hex()
  );

  // Software registers; status set wins over read clear
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_reg <= UCB_CTRL_RST;
      tx_id_reg <= UCB_TX_ID_RST;
      code_reg <= UCB_CODE_RST;
      mask_reg <= UCB_MASK_RST;
      irqm_reg <= UCB_IRQM_RST;
      stat_reg <= 4'h0;
    end else begin
      if (apb_wr && sel_ctrl) ctrl_reg <= i_pwdata[UCB_CTRL_W-1:0];
      if (apb_wr && sel_txid) tx_id_reg <= i_pwdata[28:0];
      if (apb_wr && sel_code) code_reg <= i_pwdata[28:0];
      if (apb_wr && sel_mask) mask_reg <= i_pwdata[28:0];
      if (apb_wr && sel_irqm) irqm_reg <= i_pwdata[UCB_ST_W-1:0];
      stat_reg <= stat_next;
    end
  end

  // Transmit assembly; a quiet gap closes a message and its header
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc_reg <= 64'h0000000000000000;
      tx_cnt_reg <= 4'h0;
      hdr_cnt_reg <= 2'h0;
      dyn_id_reg <= 12'h000;
      idle_reg <= 16'h0000;
      tx_pend_reg <= 1'b0;
      tx_out_reg <= '0;
    end else if (soft_rst) begin
      tx_cnt_reg <= 4'h0;
      hdr_cnt_reg <= 2'h0;
      idle_reg <= 16'h0000;
      tx_pend_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      idle_reg <= (byte_in || gap_hit || !msg_open) ? 16'h0000 : idle_reg + 16'h0001;
      if (byte_in && hdr_phase) begin
        dyn_id_reg <= {dyn_id_reg[7:0], hex_nib};
        hdr_cnt_reg <= hdr_cnt_reg + 2'h1;
      end else if (gap_hit) begin
        hdr_cnt_reg <= 2'h0;
      end
      if (go_pend) begin
        tx_out_reg <= '{ext: ctrl_reg.ext, id: id_fmt, dlc: dlc_next, data: acc_next};
        tx_cnt_reg <= 4'h0;
        tx_pend_reg <= 1'b1;
      end else begin
        tx_cnt_reg <= dlc_next;
        if (tx_sent) tx_pend_reg <= 1'b0;
      end
    end
  end

  // Receive hold and output buffer control
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      hold_reg <= '0;
      hold_vld_reg <= 1'b0;
      idx_reg <= 4'h0;
      cnt_reg <= '0;
      rd_reg <= '0;
      drain_reg <= 1'b0;
    end else if (soft_rst) begin
      hold_vld_reg <= 1'b0;
      cnt_reg <= '0;
      rd_reg <= '0;
      drain_reg <= 1'b0;
    end else begin
      if (rx_acc && !hold_vld_reg) begin
        hold_reg <= i_can_rx_frame;
        hold_vld_reg <= 1'b1;
        idx_reg <= ctrl_reg.resp_id ? 4'h0 : 4'(UCB_HDR_LEN);
      end else if (hold_fin) begin
        hold_vld_reg <= 1'b0;
      end else if (app_en) begin
        idx_reg <= idx_reg + 4'h1;
      end
      if (pop_last) begin
        drain_reg <= 1'b0;
        cnt_reg <= '0;
        rd_reg <= '0;
      end else begin
        if (pop) rd_reg <= rd_reg + CW'(1);
        if (app_en) cnt_reg <= cnt_reg + CW'(1);
        if (start_drain) drain_reg <= 1'b1;
      end
    end
  end

  // Buffer storage, no reset needed
  always_ff @(posedge i_mclk) begin
    if (app_en) buf_reg[cnt_reg[CW-1:0]] <= app_byte;
  end

  // Error light time, then one-cycle watchdog pulse
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      err_act_reg <= 1'b0;
      err_cnt_reg <= 32'h00000000;
      wdt_reg <= 1'b0;
    end else begin
      wdt_reg <= err_done;
      if (err_done) begin
        err_act_reg <= 1'b0;
      end else if (ovf_ev && !err_act_reg) begin
        err_act_reg <= 1'b1;
        err_cnt_reg <= 32'h00000000;
      end else if (err_act_reg) begin
        err_cnt_reg <= err_cnt_reg + 32'h00000001;
      end
    end
  end

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  wire [28:0] chk_mask = i_can_rx_frame.ext ? mask_reg : {18'h00000, mask_reg[10:0]};
  sequence s_ovf;
    ovf_ev && !err_act_reg;
  endsequence
  sequence s_light;
    err_act_reg && o_err_led;
  endsequence

  filt_match_a: assert property (rx_in && (((i_can_rx_frame.id ^ code_reg) & chk_mask) != 0)
    |-> !rx_acc) else $error("masked mismatch accepted");
  zero_mask_a: assert property (rx_in && mask_reg == 29'h0 |-> rx_acc)
    else $error("zero mask rejected a frame");
  reject_drop_a: assert property (rx_rej && !hold_vld_reg |=> !hold_vld_reg)
    else $error("rejected frame was held");
  range_win_a: assert property (rx_in && !i_can_rx_frame.ext && mask_reg[10:0] == 11'h7C0 &&
    code_reg[10:6] == 5'h04 |-> rx_pass == (i_can_rx_frame.id[10:0] >= 11'h100 &&
    i_can_rx_frame.id[10:0] <= 11'h13F)) else $error("range filter wrong");
  ext_bits_a: assert property (rx_in && i_can_rx_frame.ext && mask_reg == 29'h1FFFFFFF &&
    i_can_rx_frame.id[28:11] != code_reg[28:11] |-> !rx_pass)
    else $error("extended bits ignored");
  fixed_id_a: assert property (go_pend && !soft_rst && ctrl_reg.fixed_id && !ctrl_reg.ext |=>
    o_can_tx_frame.id == {18'h0, $past(tx_id_reg[10:0])})
    else $error("fixed identifier not used");
  chunk_len_a: assert property (o_can_tx_valid |-> o_can_tx_frame.dlc inside {[1:8]})
    else $error("frame length out of range");
  imm_drain_a: assert property (hold_fin && !soft_rst && !ctrl_reg.end_char && cnt_reg != '0
    |=> drain_reg)
    else $error("immediate frame not sent");
  cr_hold_a: assert property (ctrl_reg.end_char && !drain_reg && !app_cr |=> !drain_reg)
    else $error("output before end character");
  err_seq_a: assert property (s_ovf |=> s_light ##0 !o_wdt_rst)
    else $error("overflow did not light error");
  wdt_end_a: assert property ($fell(err_act_reg) |-> o_wdt_rst ##1 !o_wdt_rst)
    else $error("watchdog pulse missing");
endmodule // ucb_bridge

// ===== tb/ucb_peer.sv
`timescale 1ns/1ps
module ucb_peer
  import ucb_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Frames leaving the bridge
  input wire logic i_tx_valid,
  input wire ucb_frame_t i_tx_frame,
  input wire logic i_stall,
  output logic o_tx_ready,
  // Serial bytes leaving the bridge
  input wire logic i_out_valid,
  input wire logic [7:0] i_out_data,
  output logic o_out_ready
);
  ucb_frame_t got_frames[$];
  logic [7:0] got_bytes[$];
  // Frame sink stalls only on request, so overrun can be provoked
  assign o_tx_ready = !i_stall;
  // Serial device drains promptly; a slow one would only overrun sooner
  assign o_out_ready = 1'b1;
  // Capture each unit at its handshake edge
  always @(posedge i_mclk) begin
    if (i_nrst && i_tx_valid && o_tx_ready)
      got_frames.push_back(i_tx_frame);
    if (i_nrst && i_out_valid && o_out_ready)
      got_bytes.push_back(i_out_data);
  end
endmodule // ucb_peer

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
  import ucb_pkg::*;
  // Drivers and observed outputs
  logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sin_valid = 1'b0, rx_valid = 1'b0, stall = 1'b0;
  logic [7:0] paddr = 8'h00, sin_data = 8'h00, sout_data;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, last_err, sin_ready, sout_valid, sout_ready;
  logic tx_valid, tx_ready, err_led, wdt_rst, irq;
  ucb_frame_t tx_frame, rx_frame = '0;
  int errors = 0, check_count = 0, led_cnt = 0, wdt_cnt = 0;

  ucb_bridge #(.BUF_DEPTH(72), .ERR_CYCLES(50), .IDLE_CYCLES(8)) ucb_bridge_i (
    .i_mclk(mclk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ser_in_valid(sin_valid),
    .i_ser_in_data(sin_data), .o_ser_in_ready(sin_ready),
    .o_ser_out_valid(sout_valid), .o_ser_out_data(sout_data),
    .i_ser_out_ready(sout_ready), .o_can_tx_valid(tx_valid),
    .o_can_tx_frame(tx_frame), .i_can_tx_ready(tx_ready),
    .i_can_rx_valid(rx_valid), .i_can_rx_frame(rx_frame), .o_err_led(err_led),
    .o_wdt_rst(wdt_rst), .o_irq(irq));

  ucb_peer ucb_peer_i (
    .i_mclk(mclk), .i_nrst(nrst), .i_tx_valid(tx_valid), .i_tx_frame(tx_frame),
    .i_stall(stall), .o_tx_ready(tx_ready), .i_out_valid(sout_valid),
    .i_out_data(sout_data), .o_out_ready(sout_ready));

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  // Error light length and watchdog pulses
  always @(posedge mclk) begin
    if (err_led === 1'b1)
      led_cnt <= led_cnt + 1;
    if (wdt_rst === 1'b1)
      wdt_cnt <= wdt_cnt + 1;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; an extra idle edge keeps psel edges apart
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      errors++;
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask

  // Serial bytes back to back, valid held across the string
  task automatic send(input string s);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      sin_data <= s[i];
      sin_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (sin_ready !== 1'b1 && n < 100);
      if (sin_ready !== 1'b1)
        errors++;
    end
    sin_valid <= 1'b0;
    @(posedge mclk);
  endtask

  // Received frame held valid for cyc edges, then a gap to drain
  task automatic rxf(input logic ext, input logic [28:0] id, input string s, input int cyc);
    ucb_frame_t f;
    f = '0;
    f.ext = ext;
    f.id = id;
    f.dlc = 4'(s.len());
    for (int i = 0; i < s.len(); i++)
      f.data[8*i +: 8] = s[i];
    rx_frame <= f;
    rx_valid <= 1'b1;
    repeat (cyc) @(posedge mclk);
    rx_valid <= 1'b0;
    repeat (20) @(posedge mclk);
  endtask

  task automatic waitf(input int n);
    int k;
    k = 0;
    while (ucb_peer_i.got_frames.size() < n && k < 300) begin
      @(posedge mclk);
      k++;
    end
    if (ucb_peer_i.got_frames.size() < n)
      errors++;
  endtask

  task automatic expf(input string nm, input logic ext, input logic [28:0] id, input string s);
    ucb_frame_t f;
    f = '0;
    if (ucb_peer_i.got_frames.size() != 0)
      f = ucb_peer_i.got_frames.pop_front();
    chk(nm, {f.ext, f.id, f.dlc}, {ext, id, 4'(s.len())});
    for (int i = 0; i < s.len(); i++)
      chk(nm, f.data[8*i +: 8], s[i]);
  endtask

  task automatic expb(input string nm, input string s);
    chk(nm, ucb_peer_i.got_bytes.size(), s.len());
    for (int i = 0; i < s.len(); i++)
      chk(nm, ucb_peer_i.got_bytes[i], s[i]);
    ucb_peer_i.got_bytes.delete();
  endtask

  // Hang guard, well above the expected run of under a thousand cycles
  initial begin
    #100us;
    errors++;
    finish_test();
  end

  initial begin
    logic [28:0] t_id[10], t_code[10], t_mask[10];
    logic [9:0] t_ext, t_pass;
    t_id = '{29'h123, 29'h124, 29'h555, 29'h100, 29'h13F, 29'h140, 29'h0FF,
             29'h1ABCDE12, 29'h0ABCDE12, 29'h123};
    t_code = '{29'h123, 29'h123, 29'h123, 29'h100, 29'h100, 29'h100, 29'h100,
               29'h1ABCDE12, 29'h1ABCDE12, 29'h10000123};
    t_mask = '{29'h7FF, 29'h7FF, 29'h000, 29'h7C0, 29'h7C0, 29'h7C0, 29'h7C0,
               29'h1FFFFFFF, 29'h1FFFFFFF, 29'h1FFFFFFF};
    t_ext = 10'h180;
    t_pass = 10'h29D;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    // Register reset values, field width, unmapped place
    rd(UCB_OFF_CTRL, 32'h1, "ctrl");
    rd(UCB_OFF_TX_ID, 32'h1, "tx_id");
    rd(UCB_OFF_ACC_CODE, 32'h0, "code");
    rd(UCB_OFF_ACC_MASK, 32'h0, "mask");
    rd(UCB_OFF_STATUS, 32'h0, "status");
    rd(UCB_OFF_IRQ_MASK, 32'h0, "irq_mask");
    apb(1'b1, 8'h18, 32'hFFFFFFFF);
    chk("slverr wr", last_err, 1'b1);
    rd(8'h18, 32'h0, "unmapped");
    chk("slverr rd", last_err, 1'b1);
    apb(1'b1, UCB_OFF_ACC_CODE, 32'hFFFFFFFF);
    rd(UCB_OFF_ACC_CODE, 32'h1FFFFFFF, "code width");
    // Fixed id: nine bytes, command-like characters pass untouched
    send("$01M5678~");
    waitf(2);
    expf("fix0", 1'b0, 29'h1, "$01M5678");
    expf("fix1", 1'b0, 29'h1, "~");
    apb(1'b1, UCB_OFF_CTRL, 32'h3);
    apb(1'b1, UCB_OFF_TX_ID, 32'h1ABCDE12);
    send("AB");
    waitf(1);
    expf("fix ext", 1'b1, 29'h1ABCDE12, "AB");
    // Dynamic id from three hex characters, either letter case
    apb(1'b1, UCB_OFF_CTRL, 32'h0);
    send("0021234567");
    waitf(1);
    expf("dyn", 1'b0, 29'h2, "1234567");
    send("0aBz");
    waitf(1);
    expf("dyn case", 1'b0, 29'h0AB, "z");
    // Acceptance filter cases, immediate forwarding
    apb(1'b1, UCB_OFF_CTRL, 32'h1);
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, UCB_OFF_ACC_CODE, {3'h0, t_code[i]});
      apb(1'b1, UCB_OFF_ACC_MASK, {3'h0, t_mask[i]});
      apb(1'b0, UCB_OFF_STATUS, 32'h0);
      rxf(t_ext[i], t_id[i], "K", 1);
      chk("filt out", ucb_peer_i.got_bytes.size(), t_pass[i]);
      ucb_peer_i.got_bytes.delete();
      rd(UCB_OFF_STATUS, t_pass[i] ? 32'h2 : 32'h4, "filt st");
    end
    // Interrupt raised, cleared by read, then masked
    apb(1'b1, UCB_OFF_ACC_MASK, 32'h0);
    apb(1'b1, UCB_OFF_IRQ_MASK, 32'h2);
    rxf(1'b0, 29'h7, "K", 1);
    chk("irq set", irq, 1'b1);
    apb(1'b0, UCB_OFF_STATUS, 32'h0);
    chk("irq clr", irq, 1'b0);
    apb(1'b1, UCB_OFF_IRQ_MASK, 32'h1);
    rxf(1'b0, 29'h7, "K", 1);
    chk("irq masked", irq, 1'b0);
    apb(1'b0, UCB_OFF_STATUS, 32'h0);
    expb("imm", "KK");
    // Identifier prefix on received data
    apb(1'b1, UCB_OFF_CTRL, 32'h5);
    rxf(1'b0, 29'h2A3, "xy", 1);
    expb("resp id", "2A3xy");
    // End character mode holds data until the carriage return
    apb(1'b1, UCB_OFF_CTRL, 32'h9);
    rxf(1'b0, 29'h5, "12", 1);
    chk("held", ucb_peer_i.got_bytes.size(), 0);
    rxf(1'b0, 29'h5, "3\015", 1);
    expb("end char", "123\015");
    // Back to back frames overrun the holding stage
    apb(1'b1, UCB_OFF_CTRL, 32'h1);
    rxf(1'b0, 29'h9, "OV", 2);
    chk("ready in err", sin_ready, 1'b0);
    repeat (60) @(posedge mclk);
    chk("led time", led_cnt, 50);
    chk("wdt pulse", wdt_cnt, 1);
    chk("led off", err_led, 1'b0);
    apb(1'b0, UCB_OFF_STATUS, 32'h0);
    chk("ovf st", q[3], 1'b1);
    // Stalled frame sink: the ninth byte overruns the serial side
    stall <= 1'b1;
    send("ABCDEFGHI");
    chk("ser ovf led", err_led, 1'b1);
    repeat (60) @(posedge mclk);
    stall <= 1'b0;
    chk("ser ovf time", led_cnt, 100);
    chk("ser ovf wdt", wdt_cnt, 2);
    repeat (20) @(posedge mclk);
    chk("pend dropped", ucb_peer_i.got_frames.size(), 0);
    apb(1'b0, UCB_OFF_STATUS, 32'h0);
    chk("ser ovf st", q[3:0], 4'h8);
    finish_test();
  end
endmodule // tb
